/* hdl/sse_exec_core.sv */
// Halt and subtract instruction execution core with an APB register slave
//
// Overview of operation
// - Halt opcode clears the power-down flag
// - Halt sets the watchdog-expiry flag
// - Halt clears watchdog count and prescaler
// - Halt enters halted state, oscillator stopped
// - Literal subtract: literal minus accumulator into accumulator
// - Literal is eight bits, 0 to 255
// - File subtract: file minus accumulator, 7-bit address
// - Destination 0 writes accumulator, file untouched
// - Destination 1 writes back the file register
// - Carry set when minuend exceeds subtrahend
// - Carry set when operands are equal
// - Carry cleared on borrow, result wraps
//
// Decided for this implementation: the register addresses and register access over APB.
module sse_exec_core #(
  parameter int WDT_PRE_W = 8,
  parameter int WDT_CNT_W = 8
) (
  input  wire logic                            CLK,
  input  wire logic                            RESET_N,
  input  wire logic                            PSEL,
  input  wire logic                            PENABLE,
  input  wire logic                            PWRITE,
  input  wire logic [sse_pkg::APB_ADDR_W-1:0]  PADDR,
  input  wire logic [sse_pkg::APB_DATA_W-1:0]  PWDATA,
  output logic      [sse_pkg::APB_DATA_W-1:0]  PRDATA,
  output logic                                 PREADY,
  output logic                                 PSLVERR,
  output logic                                 HALTED,
  output logic                                 OSC_EN
);
  import sse_pkg::*;

  sse_state_t              state_reg;
  logic [BYTE_W-1:0]       acc_reg;
  logic [FADDR_W-1:0]      faddr_reg;
  logic [INSTR_W-1:0]      instr_reg;
  logic                    carry_reg;
  logic                    nibble_borrow_flag_reg;
  logic                    zero_reg;
  logic                    power_down_flag_reg;
  logic                    watchdog_expiry_flag_reg;
  logic                    halted_reg;
  logic [WDT_PRE_W-1:0]    wdt_pre_reg;
  logic [WDT_CNT_W-1:0]    watchdog_counter_reg;
  logic [APB_DATA_W-1:0]   prdata_reg;

  logic                    access;
  logic                    done;
  logic                    wr_done;
  logic                    mapped;
  logic [INSTR_W-1:0]      instr;
  logic                    instr_wr;
  logic                    exec;
  logic                    op_halt;
  logic                    op_lit;
  logic                    op_file;
  logic                    op_sub;
  logic                    dest_file;
  logic [BYTE_W-1:0]       literal;
  logic [FADDR_W-1:0]      file_addr;
  logic [BYTE_W-1:0]       minuend;
  logic [BYTE_W-1:0]       sub_diff;
  logic                    sub_carry;
  logic                    sub_nibble;
  logic                    sub_zero;
  logic                    mem_we;
  logic [FADDR_W-1:0]      mem_waddr;
  logic [BYTE_W-1:0]       mem_wdata;
  logic [FADDR_W-1:0]      mem_raddr;
  logic [BYTE_W-1:0]       mem_rdata;
  logic                    wdt_clear;
  logic                    wdt_pre_wrap;
  logic                    wdt_overflow;
  logic                    wake_req;
  logic                    kick_req;

  // Opcode recognisers, shared by execution and the checks below
  function automatic logic is_halt(input logic [INSTR_W-1:0] w);
    return w == OPC_HALT;
  endfunction

  function automatic logic is_lit_sub(input logic [INSTR_W-1:0] w);
    return w[INSTR_W-1:LIT_OPC_LSB] == LIT_OPC;
  endfunction

  function automatic logic is_file_sub(input logic [INSTR_W-1:0] w);
    return w[INSTR_W-1:FILE_OPC_LSB] == FILE_OPC;
  endfunction

  // Every transfer takes one wait state so that read data comes from a register
  always_comb begin
    access  = PSEL & PENABLE;
    PREADY  = (state_reg == ST_EXEC);
    done    = access & PREADY;
    wr_done = done & PWRITE;
    mapped  = (PADDR == OFF_CTRL) | (PADDR == OFF_INSTR) | (PADDR == OFF_ACC) |
              (PADDR == OFF_STATUS) | (PADDR == OFF_FADDR) | (PADDR == OFF_FDATA) |
              (PADDR == OFF_WDT);
  end

  // Instructions written while halted are refused with an error
  always_comb begin
    PSLVERR = done & (~mapped | (instr_wr & halted_reg));
  end

  // Transfer sequencing
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (access) begin
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Instruction decode; the word stays on PWDATA for the whole transfer
  always_comb begin
    instr     = PWDATA[INSTR_W-1:0];
    instr_wr  = PWRITE & (PADDR == OFF_INSTR);
    exec      = done & instr_wr & ~halted_reg;
    op_halt   = exec & is_halt(instr);
    op_lit    = exec & is_lit_sub(instr);
    op_file   = exec & is_file_sub(instr);
    op_sub    = op_lit | op_file;
    dest_file = instr[DEST_BIT];
    literal   = instr[BYTE_W-1:0];
    file_addr = instr[FADDR_W-1:0];
  end

  // File operand is fetched during setup so it is ready at the access phase
  always_comb begin
    mem_raddr = instr_wr ? file_addr : faddr_reg;
    minuend   = is_lit_sub(instr) ? literal : mem_rdata;
  end

  sse_sub8 #(
    .W (BYTE_W)
  ) u_sub (
    .minuend      (minuend),
    .subtrahend   (acc_reg),
    .diff         (sub_diff),
    .carry        (sub_carry),
    .nibble_carry (sub_nibble),
    .zero         (sub_zero)
  );

  // Write-back into the file register: software data path or subtract result
  always_comb begin
    if (op_file && dest_file) begin
      mem_we    = 1'b1;
      mem_waddr = file_addr;
      mem_wdata = sub_diff;
    end else begin
      mem_we    = wr_done & (PADDR == OFF_FDATA);
      mem_waddr = faddr_reg;
      mem_wdata = PWDATA[BYTE_W-1:0];
    end
  end

  sse_file_ram #(
    .AW (FADDR_W),
    .DW (BYTE_W)
  ) u_ram (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .we        (mem_we),
    .waddr     (mem_waddr),
    .wdata     (mem_wdata),
    .raddr     (mem_raddr),
    .rdata_reg (mem_rdata)
  );

  // Accumulator
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      acc_reg <= ACC_RESET;
    end else if (op_lit || (op_file && !dest_file)) begin
      acc_reg <= sub_diff;
    end else if (wr_done && PADDR == OFF_ACC) begin
      acc_reg <= PWDATA[BYTE_W-1:0];
    end
  end

  // File address pointer and last issued instruction
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      faddr_reg <= {FADDR_W{1'b0}};
      instr_reg <= {INSTR_W{1'b0}};
    end else begin
      if (wr_done && PADDR == OFF_FADDR) begin
        faddr_reg <= PWDATA[FADDR_W-1:0];
      end
      if (exec) begin
        instr_reg <= instr;
      end
    end
  end

  // Arithmetic flags; a subtract and a status write never share a cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      carry_reg              <= 1'b0;
      nibble_borrow_flag_reg <= 1'b0;
      zero_reg               <= 1'b0;
    end else if (op_sub) begin
      carry_reg              <= sub_carry;
      nibble_borrow_flag_reg <= sub_nibble;
      zero_reg               <= sub_zero;
    end else if (wr_done && PADDR == OFF_STATUS) begin
      carry_reg              <= PWDATA[ST_CARRY_BIT];
      nibble_borrow_flag_reg <= PWDATA[ST_NIBBLE_BIT];
      zero_reg               <= PWDATA[ST_ZERO_BIT];
    end
  end

  // Control strobes from software
  always_comb begin
    wake_req  = wr_done & (PADDR == OFF_CTRL) & PWDATA[CTRL_WAKE_BIT];
    kick_req  = wr_done & (PADDR == OFF_CTRL) & PWDATA[CTRL_KICK_BIT];
    wdt_clear = op_halt | kick_req;
  end

  // Watchdog prescaler and counter keep running while halted, own clock assumed
  always_ff @(posedge CLK) begin
    if (!RESET_N || wdt_clear) begin
      wdt_pre_reg <= {WDT_PRE_W{1'b0}};
    end else begin
      wdt_pre_reg <= wdt_pre_reg + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || wdt_clear) begin
      watchdog_counter_reg <= WDT_CLEAR;
    end else if (wdt_pre_wrap) begin
      watchdog_counter_reg <= watchdog_counter_reg + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_comb begin
    wdt_pre_wrap = &wdt_pre_reg;
    wdt_overflow = wdt_pre_wrap & (&watchdog_counter_reg);
  end

  // Power-down flag is cleared by halt and only restored by reset
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      power_down_flag_reg <= PD_RESET;
    end else if (op_halt) begin
      power_down_flag_reg <= 1'b0;
    end
  end

  // Expiry flag: halt or a kick sets it, an overflow clears it; the set wins
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      watchdog_expiry_flag_reg <= TO_RESET;
    end else if (op_halt || kick_req) begin
      watchdog_expiry_flag_reg <= 1'b1;
    end else if (wdt_overflow) begin
      watchdog_expiry_flag_reg <= 1'b0;
    end
  end

  // Halted state: entered by halt, left by a software wake or a watchdog overflow
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      halted_reg <= 1'b0;
    end else if (op_halt) begin
      halted_reg <= 1'b1;
    end else if (wake_req || wdt_overflow) begin
      halted_reg <= 1'b0;
    end
  end

  // Read data captured in the first access cycle
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      prdata_reg <= {APB_DATA_W{1'b0}};
    end else if (access && !PREADY && !PWRITE) begin
      prdata_reg <= {APB_DATA_W{1'b0}};
      case (PADDR)
        OFF_CTRL:   prdata_reg[ST_HALT_BIT] <= halted_reg;
        OFF_INSTR:  prdata_reg[INSTR_W-1:0] <= instr_reg;
        OFF_ACC:    prdata_reg[BYTE_W-1:0] <= acc_reg;
        OFF_STATUS: begin
          prdata_reg[ST_CARRY_BIT]  <= carry_reg;
          prdata_reg[ST_NIBBLE_BIT] <= nibble_borrow_flag_reg;
          prdata_reg[ST_ZERO_BIT]   <= zero_reg;
          prdata_reg[ST_PD_BIT]     <= power_down_flag_reg;
          prdata_reg[ST_TO_BIT]     <= watchdog_expiry_flag_reg;
          prdata_reg[ST_HALT_BIT]   <= halted_reg;
        end
        OFF_FADDR:  prdata_reg[FADDR_W-1:0] <= faddr_reg;
        OFF_FDATA:  prdata_reg[BYTE_W-1:0] <= mem_rdata;
        OFF_WDT:    prdata_reg[WDT_CNT_W-1:0] <= watchdog_counter_reg;
        default:    prdata_reg <= {APB_DATA_W{1'b0}};
      endcase
    end
  end

  // Outputs; the main oscillator enable is simply the inverse of halted
  always_comb begin
    PRDATA = prdata_reg;
    HALTED = halted_reg;
    OSC_EN = ~halted_reg;
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  logic nib_ref;
  logic gt_ref;
  logic eq_ref;
  assign nib_ref = (minuend[3:0] >= acc_reg[3:0]);
  assign gt_ref  = (minuend > acc_reg);
  assign eq_ref  = (minuend == acc_reg);

  property p_halt_pd;
    op_halt |=> !power_down_flag_reg ##1 !power_down_flag_reg;
  endproperty
  a_halt_pd: assert property (p_halt_pd) else $error("Halt did not clear power-down flag");

  property p_halt_to;
    op_halt |=> watchdog_expiry_flag_reg;
  endproperty
  a_halt_to: assert property (p_halt_to) else $error("Halt did not set expiry flag");

  property p_halt_wdt;
    op_halt |=> (watchdog_counter_reg == WDT_CLEAR) && (wdt_pre_reg == '0);
  endproperty
  a_halt_wdt: assert property (p_halt_wdt) else $error("Halt did not clear watchdog");

  property p_halt_state;
    op_halt |=> HALTED && !OSC_EN;
  endproperty
  a_halt_state: assert property (p_halt_state) else $error("Halt did not stop core");

  property p_lit_sub;
    logic [7:0] expect_v;
    (op_lit, expect_v = literal - acc_reg) |=> acc_reg == expect_v;
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("Literal subtract result wrong");

  property p_file_to_acc;
    (op_file && !dest_file) |-> !mem_we ##1 (acc_reg == $past(sub_diff));
  endproperty
  a_file_to_acc: assert property (p_file_to_acc) else $error("File subtract to acc wrong");

  property p_file_to_file;
    (op_file && dest_file) |-> (mem_waddr == instr[6:0]) ##1 $stable(acc_reg);
  endproperty
  a_file_to_file: assert property (p_file_to_file) else $error("File subtract write-back wrong");

  property p_carry_gt;
    (op_sub && gt_ref) |=> carry_reg && !zero_reg;
  endproperty
  a_carry_gt: assert property (p_carry_gt) else $error("Carry not set on positive result");

  property p_carry_eq;
    (op_sub && eq_ref) |=> carry_reg && zero_reg;
  endproperty
  a_carry_eq: assert property (p_carry_eq) else $error("Carry or zero wrong on equal");

  property p_carry_lt;
    (op_sub && !gt_ref && !eq_ref) |=> !carry_reg && !zero_reg;
  endproperty
  a_carry_lt: assert property (p_carry_lt) else $error("Carry not cleared on borrow");

  property p_nibble;
    op_sub |=> nibble_borrow_flag_reg == $past(nib_ref);
  endproperty
  a_nibble: assert property (p_nibble) else $error("Nibble carry wrong");

  c_halt:     cover property (op_halt ##1 HALTED);
  c_lit_neg:  cover property (op_lit && !gt_ref && !eq_ref);
  c_file_wb:  cover property (op_file && dest_file);
  c_wdt_wake: cover property (HALTED && wdt_overflow);
endmodule

/* hdl/sse_file_ram.sv */
// File register memory with one write port and a registered read port
module sse_file_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_reg
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents carry no reset; software must initialise them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read keeps the data output off a long combinational path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= {DW{1'b0}};
    end else begin
      rdata_reg <= mem[raddr];
    end
  end
endmodule

/* hdl/sse_pkg.sv */
// Package: constants, register map and types for the halt and subtract execution block
package sse_pkg;
  // Bus and datapath widths
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;
  localparam int INSTR_W    = 14;
  localparam int BYTE_W     = 8;
  localparam int FADDR_W    = 7;

  // Register byte offsets
  localparam logic [APB_ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFF_INSTR  = 8'h04;
  localparam logic [APB_ADDR_W-1:0] OFF_ACC    = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [APB_ADDR_W-1:0] OFF_FADDR  = 8'h10;
  localparam logic [APB_ADDR_W-1:0] OFF_FDATA  = 8'h14;
  localparam logic [APB_ADDR_W-1:0] OFF_WDT    = 8'h18;

  // Control register fields (write one to act)
  localparam int CTRL_WAKE_BIT = 0;
  localparam int CTRL_KICK_BIT = 1;

  // Status register fields
  localparam int ST_CARRY_BIT  = 0;
  localparam int ST_NIBBLE_BIT = 1;
  localparam int ST_ZERO_BIT   = 2;
  localparam int ST_PD_BIT     = 3;
  localparam int ST_TO_BIT     = 4;
  localparam int ST_HALT_BIT   = 5;

  // Reset values
  localparam logic       PD_RESET   = 1'b1;
  localparam logic       TO_RESET   = 1'b1;
  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] WDT_CLEAR  = 8'h00;

  // Instruction word fields and opcodes
  localparam logic [INSTR_W-1:0] OPC_HALT = 14'h0063;
  localparam int                 LIT_OPC_LSB  = 9;
  localparam logic [4:0]         LIT_OPC      = 5'h1e;
  localparam int                 FILE_OPC_LSB = 8;
  localparam logic [5:0]         FILE_OPC     = 6'h02;
  localparam int                 DEST_BIT     = 7;

  // Transfer sequencing
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } sse_state_t;
endpackage

/* hdl/sse_sub8.sv */
// Two's complement subtractor with carry, nibble carry and zero outputs
module sse_sub8 #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  output logic      [W-1:0] diff,
  output logic              carry,
  output logic              nibble_carry,
  output logic              zero
);
  logic [W:0] full_sum;
  logic [4:0] low_sum;

  // Add the inverted subtrahend plus one; carry out means no borrow
  always_comb begin
    full_sum     = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, 1'b1};
    low_sum      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    diff         = full_sum[W-1:0];
    carry        = full_sum[W];
    nibble_carry = low_sum[4];
    zero         = (full_sum[W-1:0] == {W{1'b0}});
  end
endmodule

/* verif/sleep_and_subtract_exec_tb.sv */
// Self-checking testbench for the halt and subtract execution core
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module sleep_and_subtract_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sse_pkg::*;

  logic                  clk         = 1'b0;
  logic                  reset_n     = 1'b0;
  logic                  psel        = 1'b0;
  logic                  penable     = 1'b0;
  logic                  pwrite      = 1'b0;
  logic [APB_ADDR_W-1:0] paddr       = 8'h00;
  logic [APB_DATA_W-1:0] pwdata      = 32'h0000_0000;
  logic [APB_DATA_W-1:0] prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  halted;
  logic                  osc_en;
  logic [31:0]           rd;
  logic                  err;
  int                    num_errors  = 0;
  int                    check_count = 0;

  // Default watchdog widths, so a cleared prescaler is told apart from a running one
  sse_exec_core #(
    .WDT_PRE_W (8),
    .WDT_CNT_W (8)
  ) sse_exec_core_i (
    .CLK     (clk),
    .RESET_N (reset_n),
    .PSEL    (psel),
    .PENABLE (penable),
    .PWRITE  (pwrite),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr),
    .HALTED  (halted),
    .OSC_EN  (osc_en)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  // Verdict and end of run
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; request held until the rising edge that samples ready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end
    // Answer taken at the same edge, then the request is released
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected zero, nibble and carry flags of minuend minus accumulator
  function automatic logic [2:0] flags(input logic [7:0] m, input logic [7:0] a);
    logic [7:0] r;
    r = m - a;
    return {r == 8'h00, m[3:0] >= a[3:0], m >= a};
  endfunction

  task automatic t_reset;
    `CHK(halted, 1'b0)
    `CHK(osc_en, 1'b1)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0018)
  endtask

  // Literal subtract over positive, zero, negative and boundary operands
  task automatic t_literal;
    logic [7:0] ks [5];
    logic [7:0] as [5];
    logic [7:0] r;
    ks = '{8'h02, 8'h02, 8'h02, 8'hff, 8'h00};
    as = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h01};
    for (int i = 0; i < 5; i++) begin
      r = ks[i] - as[i];
      apb(1'b1, OFF_ACC, {24'h0, as[i]});
      apb(1'b1, OFF_INSTR, {18'h0, LIT_OPC, i[0], ks[i]});
      apb(1'b0, OFF_ACC, 32'h0);
      `CHK(rd, {24'h0, r})
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[2:0], flags(ks[i], as[i]))
    end
  endtask

  // File subtract to the accumulator and back into the file
  task automatic t_file;
    logic [6:0] fa;
    logic [7:0] m;
    logic [7:0] r;
    for (int d = 0; d < 2; d++) begin
      fa = d[0] ? 7'h7f : 7'h00;
      m  = d[0] ? 8'h01 : 8'h03;
      r  = m - 8'h02;
      apb(1'b1, OFF_FADDR, {25'h0, fa});
      apb(1'b1, OFF_FDATA, {24'h0, m});
      apb(1'b1, OFF_ACC, 32'h0000_0002);
      apb(1'b1, OFF_INSTR, {18'h0, FILE_OPC, d[0], fa});
      apb(1'b0, OFF_ACC, 32'h0);
      `CHK(rd[7:0], d[0] ? 8'h02 : r)
      apb(1'b0, OFF_FDATA, 32'h0);
      `CHK(rd[7:0], d[0] ? r : m)
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[2:0], flags(m, 8'h02))
    end
  endtask

  // Unmapped places answer with an error and read zero
  task automatic t_unmapped;
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1'b1, 8'h3c, 32'h0000_00ff);
    `CHK(err, 1'b1)
  endtask

  // Halt after a watchdog expiry, then refusal while halted, then wake
  task automatic t_halt;
    repeat (66000) @(posedge clk);
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[ST_TO_BIT], 1'b0)
    apb(1'b1, OFF_INSTR, {18'h0, OPC_HALT});
    @(negedge clk);
    `CHK(halted, 1'b1)
    `CHK(osc_en, 1'b0)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[5:3], 3'b110)
    apb(1'b0, OFF_WDT, 32'h0);
    `CHK(rd, 32'h0)
    // Less than one prescaler period: a count here means the prescaler was not cleared
    repeat (230) @(posedge clk);
    apb(1'b0, OFF_WDT, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, OFF_INSTR, {18'h0, LIT_OPC, 1'b0, 8'h09});
    `CHK(err, 1'b1)
    apb(1'b0, OFF_ACC, 32'h0);
    `CHK(rd, 32'h0000_0002)
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    @(negedge clk);
    `CHK(halted, 1'b0)
    `CHK(osc_en, 1'b1)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd[ST_PD_BIT], 1'b0)
    // By now one prescaler period has passed, so a kick must bring the count back
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    apb(1'b0, OFF_WDT, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_literal();
    t_file();
    t_unmapped();
    t_halt();
    final_report();
  end
endmodule
